// >>> verif/ir_emitter_model.sv
// Infrared emitter on the transmitter pin: counts light pulses and their length.
// Assumes the pin is sampled on core_clk; a released pin is pulled down.
`timescale 1ns/1ns
`default_nettype none
module ir_emitter_model (
   input  wire logic core_clk,
   input  wire logic pin,
   input  wire logic pin_en,
   output wire logic lit,
   output var  int   pulses,
   output var  int   last_len
);
   int run;
   // Pull-down keeps the emitter dark while the pin is high impedance
   assign lit = pin_en ? pin : 1'b0;
   initial begin
      pulses = 0;
      last_len = 0;
      run = 0;
   end
   always @(posedge core_clk) begin
      if (lit === 1'b1)
         run <= run + 1;
      else begin
         if (run != 0) begin
            pulses <= pulses + 1;
            last_len <= run;
         end
         run <= 0;
      end
   end
endmodule
`default_nettype wire

// >>> verif/ir_transmitter_module_chk.sv
// Port checks for the IR transmitter: bus handshakes, freezes and flag clearing.
// Assumes binding to ir_transmitter_module with mode inputs synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "ir_tx_map.vh"
module ir_transmitter_module_chk (
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        stop_mode,
   input wire logic        debug_mode,
   input wire logic        ir_output_pin,
   input wire logic        irq_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_ready_return: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
      else $error("write readies not back");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read data late");
   a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h09
      |-> ##2 s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_stop_freeze: assert property ($past(stop_mode) && $past(stop_mode, 2) && !s_axi_bvalid |-> $stable(ir_output_pin))
      else $error("pin moved in stop");
   a_debug_freeze: assert property ($past(debug_mode) && $past(debug_mode, 2) && !s_axi_bvalid |-> $stable(ir_output_pin))
      else $error("pin moved in debug");
   a_irq_fall: assert property ($fell(irq_r) |-> $past(s_axi_arvalid && s_axi_arready || !s_axi_awready && !s_axi_bvalid))
      else $error("interrupt fell without access");
endmodule
`default_nettype wire

// >>> verif/ir_transmitter_module_test.sv
// Self-checking bench for the IR transmitter: registers, pin control, mark timing, freezes, flag.
// Assumes the design under verilog/ and the emitter model and checker under verif/.
`timescale 1ns/1ns
`default_nettype none
`include "ir_tx_map.vh"
module ir_transmitter_module_test;
   logic        core_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, m, m2, d;
   logic [31:0] s_axi_wdata, rd_d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  rd_r, wr_r;
   logic        wait_mode, stop_mode, debug_mode;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         ir_output_pin, ir_output_pin_en, irq_r, lit;
   int          pulses, last_len, p, miscompares = 0, check_count = 0, cycles = 0;

   ir_transmitter_module ir_transmitter_module_i (.core_clk(core_clk), .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wait_mode(wait_mode),
      .stop_mode(stop_mode), .debug_mode(debug_mode), .ir_output_pin(ir_output_pin),
      .ir_output_pin_en(ir_output_pin_en), .irq_r(irq_r));
   ir_emitter_model ir_emitter_model_i (.core_clk(core_clk), .pin(ir_output_pin),
      .pin_en(ir_output_pin_en), .lit(lit), .pulses(pulses), .last_len(last_len));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      wait_mode <= 1'($urandom_range(0, 1));
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         stop_test();
      end
   end

   function automatic logic [31:0] mark_len(input logic [7:0] mv);
      return (32'(mv) + 1) * 8;
   endfunction
   function automatic logic pin_exp(input logic l, input logic pl);
      return ~(l ^ pl);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wait_p(input int k);
      int t;
      t = pulses + k;
      for (int i = 0; i < 3000 && pulses < t; i++)
         @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      wr_r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      p = $urandom(68);
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {wait_mode, stop_mode, debug_mode} = 3'h0;
      s_axi_wstrb = 4'hF;
      cyc(16);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom_range(1, 255));
         wr(8'(i * 4), d);
         chk({30'h0, wr_r}, {30'h0, `RESP_OKAY});
         rd(8'(i * 4));
         chk(rd_d, {24'h0, d});
      end
      rd(8'h28);
      chk(rd_d, 32'h0);
      chk({30'h0, rd_r}, {30'h0, `RESP_SLVERR});
      wr(8'h28, 8'h5A);
      chk({30'h0, wr_r}, {30'h0, `RESP_SLVERR});
      wr(`OFF_OUT_CTRL, 8'hFF);
      rd(`OFF_OUT_CTRL);
      chk(rd_d, 32'hE0);
      for (int i = 0; i < 4; i++) begin
         wr(`OFF_OUT_CTRL, {i[0], i[1], 6'h20});
         cyc(3);
         chk({31'h0, ir_output_pin}, {31'h0, pin_exp(i[0], i[1])});
         chk({31'h0, ir_output_pin_en}, 32'h1);
      end
      // Baseband at prescale 1, active-high pin, so light time is the mark
      wr(`OFF_OUT_CTRL, 8'h60);
      m = 8'($urandom_range(1, 6));
      wr(`OFF_MARK_HIGH, 8'h00);
      wr(`OFF_MARK_LOW, m);
      wr(`OFF_SPACE_HIGH, 8'h00);
      wr(`OFF_SPACE_LOW, 8'h02);
      wr(`OFF_MOD_STAT, 8'h09);
      rd(`OFF_MOD_STAT);
      chk({31'h0, rd_d[7]}, 32'h1);
      wait_p(3);
      chk(32'(last_len), mark_len(m));
      m2 = m + 8'($urandom_range(1, 4));
      wr(`OFF_MARK_LOW, m2);
      wait_p(3);
      chk(32'(last_len), mark_len(m2));
      for (int i = 0; i < 2; i++) begin
         wait_p(1);
         for (int j = 0; j < 300 && lit !== 1'b1; j++)
            @(posedge core_clk);
         cyc(3);
         if (i == 0)
            stop_mode <= 1'b1;
         else
            debug_mode <= 1'b1;
         cyc(40);
         stop_mode <= 1'b0;
         debug_mode <= 1'b0;
         wait_p(1);
         chk(32'(last_len), mark_len(m2) + 40);
      end
      wr(`OFF_MOD_STAT, 8'h19);
      p = pulses;
      cyc(400);
      chk(32'(pulses - p <= 1), 32'h1);
      wr(`OFF_MOD_STAT, 8'h09);
      wait_p(2);
      chk(32'(last_len), mark_len(m2));
      wr(`OFF_MOD_STAT, 8'h0B);
      for (int j = 0; j < 300 && irq_r !== 1'b1; j++)
         @(posedge core_clk);
      chk({31'h0, irq_r}, 32'h1);
      wr(`OFF_MOD_STAT, 8'h0A);
      rd(`OFF_MOD_STAT);
      rd(`OFF_MARK_LOW);
      cyc(2);
      chk({31'h0, irq_r}, 32'h0);
      cyc(300);
      rd(`OFF_MOD_STAT);
      chk({31'h0, rd_d[7]}, 32'h0);
      chk({31'h0, ir_output_pin}, 32'h0);
      // Time mode with a long mark: each lit pulse is one primary high phase
      d = 8'($urandom_range(1, 6));
      wr(`OFF_PRI_HIGH, d);
      wr(`OFF_PRI_LOW, 8'($urandom_range(1, 6)));
      wr(`OFF_MARK_HIGH, 8'h01);
      wr(`OFF_MOD_STAT, 8'h01);
      wait_p(2);
      chk(32'(last_len), {24'h0, d});
      wr(`OFF_MOD_STAT, 8'h00);
      stop_test();
   end
endmodule

bind ir_transmitter_module ir_transmitter_module_chk ir_transmitter_module_chk_i (.core_clk(core_clk), .rstn(rstn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .stop_mode(stop_mode),
   .debug_mode(debug_mode), .ir_output_pin(ir_output_pin), .irq_r(irq_r));
`default_nettype wire

// >>> verilog/carrier_count_store.v
// Four 8-bit carrier counts with one write port and two registered read ports.
// Assumes the writer and both readers run on core_clk; words keep no reset value.
`timescale 1ns/1ns
`default_nettype none
module carrier_count_store (
   input  wire       core_clk,
   input  wire       rstn,
   input  wire       we,
   input  wire [1:0] waddr,
   input  wire [7:0] wdata,
   input  wire [1:0] ra_addr,
   output reg  [7:0] ra_data_r,
   input  wire [1:0] rb_addr,
   output reg  [7:0] rb_data_r
);
   reg [7:0] mem [0:3];

   // Contents survive reset, so software must load them before enabling
   always @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ra_data_r <= 8'h00;
         rb_data_r <= 8'h00;
      end else begin
         ra_data_r <= mem[ra_addr];
         rb_data_r <= mem[rb_addr];
      end
   end
endmodule
`default_nettype wire

// >>> verilog/ir_transmitter_module.v
// Infrared carrier modulator transmitter: carrier generator, modulator, output stage and end-of-cycle flag.
// Assumes an AXI4-Lite master on core_clk; mode inputs come from same-clock power/debug logic.
//
// Operation
// - FSK extended space keeps counting carrier clocks and swapping sets each period.
// - No readable bit shows which carrier set is active.
// - Extended space ends after the space of the period where it was cleared.
// - Extended space silences following periods' mark and space, sets still alternating.
// - Enabled drives pin from modulator; disabled drives pin from the software latch.
// - Polarity bit chooses active high or active low pin drive.
// - Flag sets when enable rises while modulator idle.
// - Flag sets at every cycle end while enable stays set.
// - Re-enable before cycle end sets flag only at that cycle end.
// - No flag at end of final cycle after enable cleared.
// - Status read then mark-low or space-low access clears the flag.
// - Interrupt request while flag and its enable are both set.
// - Cycle end loads counter and space register from the buffers.
// - Reload happens every cycle end regardless of flag state.
// - Wait mode leaves operation untouched.
// - Stop halts all counting; deep stops lose registers.
// - Light stop keeps every register and resumes where it halted.
// - Debug mode suspends counting until user mode returns.
// - Time mode uses primary counts; FSK alternates primary and secondary.
// - Carrier counts are 8-bit, undefined at power-up, kept through reset.
// - 8-bit up counter matches active count, restarts and toggles carrier.
// - 17-bit down counter opens gate while zero or above, space compare after underflow.
// - FSK swaps count pairs each time a space period expires.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ir_tx_map.vh"
module ir_transmitter_module (
   input  wire        core_clk,
   input  wire        rstn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        wait_mode,
   input  wire        stop_mode,
   input  wire        debug_mode,
   output reg         ir_output_pin,
   output reg         ir_output_pin_en,
   output reg         irq_r
);
   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr[7:2] == off[7:2]);
      end
   endfunction

   function mapped;
      input [7:0] addr;
      begin
         mapped = (addr[7:2] <= `OFF_SPACE_LOW >> 2);
      end
   endfunction

   // Write channel state
   reg        aw_have_r;
   reg        w_have_r;
   reg [7:0]  waddr_r;
   reg [7:0]  wdata_r;
   reg        wbyte_r;
   // Read channel state
   reg        rstage_r;
   reg [7:0]  raddr_r;
   // Control registers
   reg [6:0]  msc_r;
   reg        flag_r;
   reg [2:0]  oc_r;
   reg [7:0]  mark_hi_r;
   reg [7:0]  mark_lo_r;
   reg [7:0]  space_hi_r;
   reg [7:0]  space_lo_r;
   reg        armed_r;
   // Engine state
   reg        active_r;
   reg [2:0]  pre_r;
   reg [2:0]  div8_r;
   reg [7:0]  cg_cnt_r;
   reg        phase_r;
   reg        sec_r;
   reg [16:0] mcnt_r;
   reg [15:0] spc_r;
   reg        exsp_r;

   wire [7:0] store_rd;
   wire [7:0] cg_cmp;

   wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
   wire rd_take  = s_axi_arvalid && s_axi_arready;
   wire wr_cg    = do_write && wbyte_r && (waddr_r[7:2] <= `OFF_SEC_LOW >> 2);

   wire en       = msc_r[`MSC_EN];
   wire fsk      = msc_r[`MSC_FSK];
   wire base     = msc_r[`MSC_BASE];
   // Wait mode has no effect; stop and debug freeze every counter in place
   wire run      = !(stop_mode || debug_mode);
   wire unused_w = wait_mode;

   wire [2:0] div_mask = (msc_r[`MSC_DIV_HI:`MSC_DIV_LO] == 2'h0) ? 3'h0 :
                         (msc_r[`MSC_DIV_HI:`MSC_DIV_LO] == 2'h1) ? 3'h1 :
                         (msc_r[`MSC_DIV_HI:`MSC_DIV_LO] == 2'h2) ? 3'h3 : 3'h7;
   wire cmt_tick = run && active_r && ((pre_r & div_mask) == div_mask);
   wire div8_tick = cmt_tick && (div8_r == `MOD_TIME_DIV);

   wire start    = run && en && !active_r;
   wire cg_run   = cmt_tick && !base;
   wire cg_match = cg_run && (cg_cnt_r == cg_cmp);
   wire cg_rise  = cg_match && !phase_r;
   // FSK counts carrier periods, time and baseband count prescaled clocks divided by 8
   wire mtick    = fsk ? cg_rise : div8_tick;
   wire sign     = mcnt_r[16];
   wire eoc      = run && active_r && sign && ((~mcnt_r[15:0]) == spc_r);

   reg phase_nxt;
   reg sec_nxt;
   always @* begin
      phase_nxt = phase_r;
      sec_nxt = sec_r;
      if (start) begin
         phase_nxt = 1'b1;
         sec_nxt = 1'b0;
      end else begin
         if (cg_match) begin
            phase_nxt = !phase_r;
         end
         // Sets swap only at a cycle end in FSK; a secondary set chosen before FSK is cleared stays in use
         if (eoc && fsk) begin
            sec_nxt = !sec_r;
         end
      end
   end

   // Port B looks ahead so the compare value is ready when the counter restarts
   carrier_count_store u_store (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .we        (wr_cg),
      .waddr     ({waddr_r[3], ~waddr_r[2]}),
      .wdata     (wdata_r),
      .ra_addr   ({s_axi_araddr[3], ~s_axi_araddr[2]}),
      .ra_data_r (store_rd),
      .rb_addr   ({sec_nxt, phase_nxt}),
      .rb_data_r (cg_cmp)
   );

   wire clr_access = armed_r && ((rd_take && (hit(s_axi_araddr, `OFF_MARK_LOW) || hit(s_axi_araddr, `OFF_SPACE_LOW)))
                     || (do_write && (hit(waddr_r, `OFF_MARK_LOW) || hit(waddr_r, `OFF_SPACE_LOW))));
   wire flag_set   = start || (eoc && en);

   // AXI4-Lite write path
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         waddr_r <= 8'h00;
         wdata_r <= 8'h00;
         wbyte_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_r <= s_axi_wdata[7:0];
            wbyte_r <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(waddr_r) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // AXI4-Lite read path: answer two cycles after the address is taken
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
         rstage_r <= 1'b0;
         raddr_r <= 8'h00;
      end else begin
         rstage_r <= 1'b0;
         if (rd_take) begin
            s_axi_arready <= 1'b0;
            raddr_r <= s_axi_araddr;
            rstage_r <= 1'b1;
         end
         if (rstage_r) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(raddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            s_axi_rdata <= 32'h00000000;
            // The active carrier set is deliberately not visible here
            if (raddr_r[7:2] <= `OFF_SEC_LOW >> 2) begin
               s_axi_rdata <= {24'h000000, store_rd};
            end else if (hit(raddr_r, `OFF_OUT_CTRL)) begin
               s_axi_rdata <= {24'h000000, oc_r, 5'h00};
            end else if (hit(raddr_r, `OFF_MOD_STAT)) begin
               s_axi_rdata <= {24'h000000, flag_r, msc_r};
            end else if (hit(raddr_r, `OFF_MARK_HIGH)) begin
               s_axi_rdata <= {24'h000000, mark_hi_r};
            end else if (hit(raddr_r, `OFF_MARK_LOW)) begin
               s_axi_rdata <= {24'h000000, mark_lo_r};
            end else if (hit(raddr_r, `OFF_SPACE_HIGH)) begin
               s_axi_rdata <= {24'h000000, space_hi_r};
            end else if (hit(raddr_r, `OFF_SPACE_LOW)) begin
               s_axi_rdata <= {24'h000000, space_lo_r};
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Period buffers keep their contents through reset
   always @(posedge core_clk) begin
      if (do_write && wbyte_r) begin
         if (hit(waddr_r, `OFF_MARK_HIGH)) begin
            mark_hi_r <= wdata_r;
         end
         if (hit(waddr_r, `OFF_MARK_LOW)) begin
            mark_lo_r <= wdata_r;
         end
         if (hit(waddr_r, `OFF_SPACE_HIGH)) begin
            space_hi_r <= wdata_r;
         end
         if (hit(waddr_r, `OFF_SPACE_LOW)) begin
            space_lo_r <= wdata_r;
         end
      end
   end

   // Control, flag and interrupt request
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         msc_r <= `MSC_RESET;
         oc_r <= `OC_RESET;
         flag_r <= 1'b0;
         armed_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         if (do_write && wbyte_r && hit(waddr_r, `OFF_MOD_STAT)) begin
            msc_r <= wdata_r[6:0];
         end
         if (do_write && wbyte_r && hit(waddr_r, `OFF_OUT_CTRL)) begin
            oc_r <= wdata_r[7:5];
         end
         if (rd_take && hit(s_axi_araddr, `OFF_MOD_STAT)) begin
            armed_r <= 1'b1;
         end else if (clr_access) begin
            armed_r <= 1'b0;
         end
         // A new event in the clearing cycle keeps the flag set
         flag_r <= flag_set || (flag_r && !clr_access);
         // Stays high until software clears the flag or the enable
         irq_r <= (flag_set || (flag_r && !clr_access)) && msc_r[`MSC_IRQEN];
      end
   end

   // Prescaler, carrier generator and modulator
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         active_r <= 1'b0;
         pre_r <= 3'h0;
         div8_r <= 3'h0;
         cg_cnt_r <= `CG_RESTART;
         phase_r <= 1'b1;
         sec_r <= 1'b0;
         mcnt_r <= 17'h00000;
         spc_r <= 16'h0000;
         exsp_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         sec_r <= sec_nxt;
         if (start) begin
            active_r <= 1'b1;
            pre_r <= 3'h0;
            div8_r <= 3'h0;
            cg_cnt_r <= `CG_RESTART;
            mcnt_r <= {1'b0, mark_hi_r, mark_lo_r};
            spc_r <= {space_hi_r, space_lo_r};
            exsp_r <= msc_r[`MSC_EXSP];
         end else if (run && active_r) begin
            pre_r <= pre_r + 3'h1;
            // Restart at each reload so every mark spans whole divided ticks
            if (eoc) begin
               div8_r <= 3'h0;
            end else if (cmt_tick) begin
               div8_r <= div8_r + 3'h1;
            end
            if (cg_match) begin
               cg_cnt_r <= `CG_RESTART;
            end else if (cg_run) begin
               cg_cnt_r <= cg_cnt_r + 8'h01;
            end
            if (eoc) begin
               // Reload happens whether or not the flag was serviced
               mcnt_r <= {1'b0, mark_hi_r, mark_lo_r};
               spc_r <= {space_hi_r, space_lo_r};
               // Sampled at each period start, so the space of the clearing period finishes
               exsp_r <= msc_r[`MSC_EXSP];
               // Disabled mid-cycle: this cycle was the last one
               active_r <= en;
            end else if (mtick) begin
               mcnt_r <= mcnt_r - 17'h00001;
            end
         end
      end
   end

   // Gate opens only while the counter is zero or above and no extended space runs
   wire mod_out = active_r && !sign && !exsp_r && (base || phase_r);
   wire pin_lvl = en ? mod_out : oc_r[`OC_LATCH - 5];

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ir_output_pin <= 1'b0;
         ir_output_pin_en <= 1'b0;
      end else begin
         ir_output_pin <= oc_r[`OC_POL - 5] ? pin_lvl : !pin_lvl;
         ir_output_pin_en <= oc_r[`OC_PINEN - 5];
      end
   end
endmodule
`default_nettype wire

// >>> verilog/ir_tx_map.vh
// Register map, field positions, reset values and timing counts of the IR transmitter.
// Included by the transmitter, its checker and its test bench; definitions only.
`ifndef IR_TX_MAP_VH
`define IR_TX_MAP_VH

// Byte offsets on the AXI4-Lite register bus
`define OFF_PRI_HIGH    8'h00
`define OFF_PRI_LOW     8'h04
`define OFF_SEC_HIGH    8'h08
`define OFF_SEC_LOW     8'h0C
`define OFF_OUT_CTRL    8'h10
`define OFF_MOD_STAT    8'h14
`define OFF_MARK_HIGH   8'h18
`define OFF_MARK_LOW    8'h1C
`define OFF_SPACE_HIGH  8'h20
`define OFF_SPACE_LOW   8'h24

// mod_status_control_reg fields
`define MSC_EN          0
`define MSC_IRQEN       1
`define MSC_FSK         2
`define MSC_BASE        3
`define MSC_EXSP        4
`define MSC_DIV_LO      5
`define MSC_DIV_HI      6
`define MSC_FLAG        7
`define MSC_RESET       7'h00

// output_control_reg fields
`define OC_PINEN        5
`define OC_POL          6
`define OC_LATCH        7
`define OC_RESET        3'h0

// Store word index: {secondary set, high phase}
`define IDX_PRI_LOW     2'h0
`define IDX_PRI_HIGH    2'h1
`define IDX_SEC_LOW     2'h2
`define IDX_SEC_HIGH    2'h3

// Timing counts
`define MOD_TIME_DIV    3'h7
`define CG_RESTART      8'h01

// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif
